// ==== pocps_pkg.sv ====
// Package: constants and carrier types of the clock synthesizer block
// ------------------------------------------------------------------
// Contract
// RULE1: Output clock from ratio, duty and phase
// RULE2: Eight equal oscillator phases shift outputs
// RULE3: Zero degree tap rises before 45 degree
// RULE4: Any counter may use any phase tap
// RULE5: Odd ratios; equal counter adds cycle delay
// RULE6: All output counters are identical
// RULE7: Select drives reference mux directly, unsynchronised
// RULE8: Software holds reset while switching reference
// RULE9: Ref over D equals oscillator over M
// RULE10: Output equals ref times M over D, O
// RULE11: Lost feedback drives oscillator to maximum
// RULE12: Tap phase relation kept across frequency
// RULE13: Output ratio 1 to 128, default 1
// RULE14: Input divider 1 to 52, default 1
// RULE15: Feedback multiplier 1 to 64, default 1
// RULE16: Offset is delay cycles plus one tap
// ------------------------------------------------------------------
package pocps_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int N_OUT = 4;
	localparam int N_TAP = 8;
	// ------------------------------------------------------------
	// Register offsets and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIVS = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_OCFG = 8'h20;
	localparam int CTRL_HOLD_BIT = 0;
	localparam int CTRL_FBEXT_BIT = 1;
	localparam int CTRL_FBTAP_POS = 2;
	localparam int DIVS_IN_POS = 0;
	localparam int DIVS_MULT_POS = 8;
	localparam int OCFG_RATIO_POS = 0;
	localparam int OCFG_HIGH_POS = 8;
	localparam int OCFG_TAP_POS = 16;
	localparam int OCFG_DELAY_POS = 24;
	localparam int IRQ_LOCK_BIT = 0;
	localparam int IRQ_UNLOCK_BIT = 1;
	localparam int IRQ_FBLOST_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// Reset values and loop constants
	// ------------------------------------------------------------
	localparam logic [5:0] IN_DIV_MAX_M1 = 6'h33;
	localparam logic [7:0] HIGH_RESET = 8'h01;
	localparam logic [15:0] FW_RESET = 16'h0400;
	localparam logic [15:0] FW_MAX = 16'hffff;
	localparam logic [15:0] FW_STEP = 16'h0008;
	localparam logic [4:0] LOCK_CNT = 5'h10;
	localparam logic [7:0] FB_TIMEOUT = 8'h20;
	localparam logic [2:0] PHASE_RESET = 3'h7;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LOOP_HOLD = 2'b00,
		LOOP_ACQ = 2'b01,
		LOOP_LOCK = 2'b10,
		LOOP_LOST = 2'b11
	} pocps_loop_t;
	typedef struct packed {
		logic [7:0] delay;
		logic [2:0] tap;
		logic [7:0] high;
		logic [6:0] ratio_m1;
	} pocps_ocfg_t;
	typedef struct packed {
		logic [7:0] dly;
		logic [6:0] cnt;
		logic out;
	} pocps_octr_t;
	typedef struct packed {
		logic [1:0] pri;
		logic [1:0] alt;
		logic [1:0] fbin;
		logic ref_d;
		logic fbin_d;
		logic hold;
		logic fb_ext;
		logic [2:0] fb_tap;
		logic [5:0] div_m1;
		logic [5:0] mult_m1;
		pocps_ocfg_t [N_OUT-1:0] ocfg;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] acc;
		logic [15:0] fw;
		logic [2:0] phase;
		logic started;
		logic [7:0] taps;
		logic [5:0] ref_div;
		logic [5:0] fb_div;
		logic signed [3:0] err;
		logic [4:0] lock_cnt;
		logic [7:0] miss_cnt;
		pocps_loop_t loop;
		pocps_octr_t [N_OUT-1:0] octr;
		logic fbout;
	} pocps_state_t;
endpackage

// ==== pocps_top.sv ====
// Module: digital clock synthesizer with phase-tapped output counters
`timescale 1ns/10ps
module pocps_top (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// AXI4-Lite write channels
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// AXI4-Lite read channels
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// Reference and feedback pins
	input wire logic PRIMARY_REF_CLOCK_I,
	input wire logic ALTERNATE_REF_CLOCK_I,
	input wire logic REF_INPUT_SELECT_I,
	input wire logic FEEDBACK_CLOCK_IN_I,
	// Synthesized clocks and status
	output logic FEEDBACK_CLOCK_OUT_O,
	output logic [pocps_pkg::N_OUT-1:0] OUTPUT_CLOCK_O,
	output logic [7:0] OSC_PHASE_O,
	output logic LOCKED_O,
	output logic IRQ_O
);
	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
		merge = old;
	endfunction

	function automatic logic small_err(input logic signed [3:0] e);
		small_err = (e >= -4'sd1) && (e <= 4'sd1);
	endfunction

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	pocps_pkg::pocps_state_t s_reg;
	pocps_pkg::pocps_state_t s_next;
	logic ref_mux;
	logic [7:0] tap_rise;
	logic step;
	logic ref_ev;
	logic fb_ev;
	logic [2:0] ev;

	// Deliberately no synchroniser here: the select steers the mux
	// directly, so a switch under a live loop can clip a pulse.
	assign ref_mux = REF_INPUT_SELECT_I ? s_reg.alt[1] : s_reg.pri[1]; // RULE7

	always_comb begin
		pocps_pkg::pocps_ocfg_t c;
		pocps_pkg::pocps_octr_t t;
		logic [7:0] ra;
		logic [31:0] wv;
		logic [16:0] sum;
		logic [2:0] ph_inc;
		s_next = s_reg;
		c = '0;
		t = '0;
		ra = '0;
		wv = '0;
		sum = '0;
		ph_inc = '0;
		ev = 3'h0;
		s_next.pri = {s_reg.pri[0], PRIMARY_REF_CLOCK_I};
		s_next.alt = {s_reg.alt[0], ALTERNATE_REF_CLOCK_I};
		s_next.fbin = {s_reg.fbin[0], FEEDBACK_CLOCK_IN_I};
		s_next.ref_d = ref_mux;
		s_next.fbin_d = s_reg.fbin[1];

		// --------------------------------------------------------
		// Register bus
		// --------------------------------------------------------
		if (S_AXI_AWVALID_I && !s_reg.aw_have) begin
			s_next.aw_have = 1'b1;
			s_next.aw_addr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && !s_reg.w_have) begin
			s_next.w_have = 1'b1;
			s_next.wdata = S_AXI_WDATA_I;
			s_next.wstrb = S_AXI_WSTRB_I;
		end
		if (s_reg.bvalid && S_AXI_BREADY_I) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
			s_next.aw_have = 1'b0;
			s_next.w_have = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = pocps_pkg::RESP_OKAY;
			ra = {s_reg.aw_addr[7:2], 2'b00};
			unique case (ra)
				pocps_pkg::OFS_CTRL: begin
					wv = merge({27'h0, s_reg.fb_tap, s_reg.fb_ext,
						s_reg.hold}, s_reg.wdata, s_reg.wstrb);
					s_next.hold = wv[pocps_pkg::CTRL_HOLD_BIT];
					s_next.fb_ext = wv[pocps_pkg::CTRL_FBEXT_BIT];
					s_next.fb_tap = wv[pocps_pkg::CTRL_FBTAP_POS +: 3];
				end
				pocps_pkg::OFS_DIVS: begin
					wv = merge({18'h0, s_reg.mult_m1, 2'h0, s_reg.div_m1},
						s_reg.wdata, s_reg.wstrb);
					s_next.div_m1 = wv[pocps_pkg::DIVS_IN_POS +: 6]; // RULE14
					if (s_next.div_m1 > pocps_pkg::IN_DIV_MAX_M1) begin
						s_next.div_m1 = pocps_pkg::IN_DIV_MAX_M1; // RULE14
					end
					s_next.mult_m1 = wv[pocps_pkg::DIVS_MULT_POS +: 6]; // RULE15
				end
				pocps_pkg::OFS_IRQ_MASK: begin
					wv = merge({29'h0, s_reg.irq_mask}, s_reg.wdata,
						s_reg.wstrb);
					s_next.irq_mask = wv[2:0];
				end
				pocps_pkg::OFS_STATUS, pocps_pkg::OFS_IRQ_STAT: begin
				end
				default: begin
					s_next.bresp = pocps_pkg::RESP_SLVERR;
					for (int i = 0; i < pocps_pkg::N_OUT; i++) begin
						if (ra == pocps_pkg::OFS_OCFG + 8'(4 * i)) begin
							c = s_reg.ocfg[i];
							wv = merge({c.delay, 5'h0, c.tap, c.high, 1'b0,
								c.ratio_m1}, s_reg.wdata, s_reg.wstrb);
							c.ratio_m1 = wv[pocps_pkg::OCFG_RATIO_POS +: 7]; // RULE13
							c.high = wv[pocps_pkg::OCFG_HIGH_POS +: 8];
							c.tap = wv[pocps_pkg::OCFG_TAP_POS +: 3];
							c.delay = wv[pocps_pkg::OCFG_DELAY_POS +: 8];
							s_next.ocfg[i] = c; // RULE6
							s_next.bresp = pocps_pkg::RESP_OKAY;
						end
					end
				end
			endcase
		end
		if (s_reg.rvalid && S_AXI_RREADY_I) begin
			s_next.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_I && !s_reg.rvalid) begin
			ra = {S_AXI_ARADDR_I[7:2], 2'b00};
			s_next.rvalid = 1'b1;
			s_next.rresp = pocps_pkg::RESP_OKAY;
			s_next.rdata = 32'h0;
			unique case (ra)
				pocps_pkg::OFS_CTRL:
					s_next.rdata = {27'h0, s_reg.fb_tap, s_reg.fb_ext,
						s_reg.hold};
				pocps_pkg::OFS_DIVS:
					s_next.rdata = {18'h0, s_reg.mult_m1, 2'h0, s_reg.div_m1};
				pocps_pkg::OFS_STATUS:
					s_next.rdata = {s_reg.fw, 8'h0, 3'h0, s_reg.started,
						2'h0, s_reg.loop};
				pocps_pkg::OFS_IRQ_STAT: begin
					s_next.rdata = {29'h0, s_reg.irq_stat};
					s_next.irq_stat = 3'h0;
				end
				pocps_pkg::OFS_IRQ_MASK:
					s_next.rdata = {29'h0, s_reg.irq_mask};
				default: begin
					s_next.rresp = pocps_pkg::RESP_SLVERR;
					for (int i = 0; i < pocps_pkg::N_OUT; i++) begin
						if (ra == pocps_pkg::OFS_OCFG + 8'(4 * i)) begin
							c = s_reg.ocfg[i];
							s_next.rdata = {c.delay, 5'h0, c.tap, c.high, 1'b0,
								c.ratio_m1};
							s_next.rresp = pocps_pkg::RESP_OKAY;
						end
					end
				end
			endcase
		end

		// --------------------------------------------------------
		// Oscillator: one phase step per accumulator carry
		// --------------------------------------------------------
		sum = {1'b0, s_reg.acc} + {1'b0, s_reg.fw};
		step = (s_reg.loop != pocps_pkg::LOOP_HOLD) && sum[16];
		ph_inc = s_reg.phase + 3'h1;
		for (int k = 0; k < pocps_pkg::N_TAP; k++) begin
			tap_rise[k] = step && (ph_inc == 3'(k)); // RULE2
		end
		if (s_reg.loop != pocps_pkg::LOOP_HOLD) begin
			s_next.acc = sum[15:0];
		end
		if (step) begin
			s_next.phase = ph_inc;
			// Taps join one by one, so none rises before tap 0
			s_next.taps[ph_inc] = 1'b1; // RULE2
			s_next.taps[ph_inc + 3'h4] = 1'b0;
			// Phase starts at 7 so tap 0 is always the first to rise
			if (ph_inc == 3'h0) begin
				s_next.started = 1'b1; // RULE3
			end
		end

		// --------------------------------------------------------
		// Dividers and phase-frequency comparison
		// --------------------------------------------------------
		ref_ev = 1'b0;
		fb_ev = 1'b0;
		if (ref_mux && !s_reg.ref_d) begin
			if (s_reg.ref_div >= s_reg.div_m1) begin
				s_next.ref_div = 6'h0;
				ref_ev = 1'b1; // RULE9
			end else begin
				s_next.ref_div = s_reg.ref_div + 6'h1;
			end
		end
		if (tap_rise[s_reg.fb_tap]) begin
			s_next.fb_div = (s_reg.fb_div == s_reg.mult_m1) ? 6'h0 :
				s_reg.fb_div + 6'h1; // RULE15
		end
		s_next.fbout = (s_reg.mult_m1 == 6'h0) ?
			s_reg.taps[s_reg.fb_tap] :
			s_reg.started && (s_next.fb_div <= {1'b0, s_reg.mult_m1[5:1]});
		if (s_reg.fb_ext) begin
			fb_ev = s_reg.fbin[1] && !s_reg.fbin_d;
		end else begin
			fb_ev = tap_rise[s_reg.fb_tap] && (s_reg.fb_div == s_reg.mult_m1);
		end
		if (ref_ev && !fb_ev && s_reg.err != 4'sd7) begin
			s_next.err = s_reg.err + 4'sd1;
		end else if (fb_ev && !ref_ev && s_reg.err != -4'sd7) begin
			s_next.err = s_reg.err - 4'sd1;
		end

		// --------------------------------------------------------
		// Loop control
		// --------------------------------------------------------
		if (fb_ev) begin
			s_next.miss_cnt = 8'h0;
		end else if (ref_ev && s_reg.miss_cnt != pocps_pkg::FB_TIMEOUT) begin
			s_next.miss_cnt = s_reg.miss_cnt + 8'h1;
		end
		if (ref_ev && s_reg.loop != pocps_pkg::LOOP_LOST) begin
			if (s_next.err > 4'sd0 && s_reg.fw <= 16'hffff -
				pocps_pkg::FW_STEP) begin
				s_next.fw = s_reg.fw + pocps_pkg::FW_STEP; // RULE9
			end else if (s_next.err < 4'sd0 && s_reg.fw >
				pocps_pkg::FW_STEP) begin
				s_next.fw = s_reg.fw - pocps_pkg::FW_STEP; // RULE9
			end
			s_next.lock_cnt = small_err(s_next.err) ?
				s_reg.lock_cnt + 5'h1 : 5'h0;
		end
		unique case (s_reg.loop)
			pocps_pkg::LOOP_HOLD:
				if (!s_reg.hold) begin
					s_next.loop = pocps_pkg::LOOP_ACQ;
				end
			pocps_pkg::LOOP_ACQ:
				if (s_next.lock_cnt >= pocps_pkg::LOCK_CNT) begin
					s_next.loop = pocps_pkg::LOOP_LOCK;
					ev[pocps_pkg::IRQ_LOCK_BIT] = 1'b1;
				end
			pocps_pkg::LOOP_LOCK:
				if (ref_ev && !small_err(s_next.err)) begin
					s_next.loop = pocps_pkg::LOOP_ACQ;
					s_next.lock_cnt = 5'h0;
					ev[pocps_pkg::IRQ_UNLOCK_BIT] = 1'b1;
				end
			pocps_pkg::LOOP_LOST: begin
				// Without feedback the loop only ever pushes up
				s_next.fw = pocps_pkg::FW_MAX; // RULE11
				if (fb_ev) begin
					s_next.loop = pocps_pkg::LOOP_ACQ;
					s_next.lock_cnt = 5'h0;
					s_next.err = 4'sd0;
				end
			end
		endcase
		if (s_reg.loop != pocps_pkg::LOOP_LOST &&
			s_reg.loop != pocps_pkg::LOOP_HOLD &&
			s_next.miss_cnt == pocps_pkg::FB_TIMEOUT) begin
			s_next.loop = pocps_pkg::LOOP_LOST;
			s_next.fw = pocps_pkg::FW_MAX; // RULE11
			ev[pocps_pkg::IRQ_FBLOST_BIT] = 1'b1;
			ev[pocps_pkg::IRQ_UNLOCK_BIT] = s_reg.loop ==
				pocps_pkg::LOOP_LOCK;
		end

		// --------------------------------------------------------
		// Output counters
		// --------------------------------------------------------
		for (int i = 0; i < pocps_pkg::N_OUT; i++) begin
			c = s_reg.ocfg[i];
			t = s_reg.octr[i];
			if (tap_rise[c.tap]) begin // RULE4
				if (t.dly != 8'h0) begin
					t.dly = t.dly - 8'h01; // RULE16
				end else if (t.cnt == c.ratio_m1) begin
					t.cnt = 7'h0; // RULE5
				end else begin
					t.cnt = t.cnt + 7'h1; // RULE13
				end
			end
			// Whole phase in oscillator units, so it tracks frequency
			t.out = s_reg.started && (t.dly == 8'h0) &&
				((c.ratio_m1 == 7'h0) ? s_reg.taps[c.tap] :
				({1'b0, t.cnt} < c.high)); // RULE1 RULE10 RULE12
			s_next.octr[i] = t;
		end

		// --------------------------------------------------------
		// Hold: counters restart together from a known phase
		// --------------------------------------------------------
		if (s_reg.hold) begin // RULE8
			s_next.loop = pocps_pkg::LOOP_HOLD;
			s_next.acc = 16'h0;
			s_next.fw = pocps_pkg::FW_RESET;
			s_next.phase = pocps_pkg::PHASE_RESET;
			s_next.started = 1'b0;
			s_next.ref_div = 6'h0;
			s_next.fb_div = 6'h0;
			s_next.err = 4'sd0;
			s_next.lock_cnt = 5'h0;
			s_next.miss_cnt = 8'h0;
			s_next.fbout = 1'b0;
			s_next.taps = 8'h00;
			// Settings written this cycle, so count and ratio agree
			for (int i = 0; i < pocps_pkg::N_OUT; i++) begin
				s_next.octr[i].dly = s_next.ocfg[i].delay;
				s_next.octr[i].cnt = s_next.ocfg[i].ratio_m1;
				s_next.octr[i].out = 1'b0;
			end
		end
		// Set wins over the read clear
		s_next.irq_stat = s_next.irq_stat | ev;
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.hold <= 1'b1;
			s_reg.fw <= pocps_pkg::FW_RESET;
			s_reg.phase <= pocps_pkg::PHASE_RESET;
			s_reg.loop <= pocps_pkg::LOOP_HOLD;
			for (int i = 0; i < pocps_pkg::N_OUT; i++) begin
				s_reg.ocfg[i].high <= pocps_pkg::HIGH_RESET;
			end
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign S_AXI_AWREADY_O = !s_reg.aw_have;
	assign S_AXI_WREADY_O = !s_reg.w_have;
	assign S_AXI_BVALID_O = s_reg.bvalid;
	assign S_AXI_BRESP_O = s_reg.bresp;
	assign S_AXI_ARREADY_O = !s_reg.rvalid;
	assign S_AXI_RVALID_O = s_reg.rvalid;
	assign S_AXI_RRESP_O = s_reg.rresp;
	assign S_AXI_RDATA_O = s_reg.rdata;
	assign FEEDBACK_CLOCK_OUT_O = s_reg.fbout;
	assign OSC_PHASE_O = s_reg.taps;
	assign LOCKED_O = s_reg.loop == pocps_pkg::LOOP_LOCK;
	assign IRQ_O = |(s_reg.irq_stat & s_reg.irq_mask);
	always_comb begin
		for (int i = 0; i < pocps_pkg::N_OUT; i++) begin
			OUTPUT_CLOCK_O[i] = s_reg.octr[i].out;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!rst_n);

	sequence seq_hold_release;
		s_reg.hold ##1 !s_reg.hold;
	endsequence
	sequence seq_first_step;
		!s_reg.started ##1 s_reg.started;
	endsequence

	tap_order_a: assert property (seq_first_step |-> // RULE3
		s_reg.phase == 3'h0 && s_reg.taps == 8'h01)
		else $error("first oscillator tap was not tap zero");
	tap_spacing_a: assert property ($rose(s_reg.taps[1]) |-> // RULE2
		s_reg.taps[0] && !s_reg.taps[5])
		else $error("tap one rose out of order");
	hold_restart_a: assert property (seq_hold_release |-> // RULE8
		!s_reg.started && s_reg.loop == pocps_pkg::LOOP_HOLD)
		else $error("oscillator ran during hold");
	count_range_a: assert property (s_reg.octr[0].dly == 8'h0 |-> // RULE13
		s_reg.octr[0].cnt <= s_reg.ocfg[0].ratio_m1)
		else $error("output counter passed its ratio");
	delay_quiet_a: assert property (s_reg.octr[3].dly != 8'h0 |-> // RULE16
		!s_reg.octr[3].out)
		else $error("output ran during start delay");
	in_div_a: assert property (s_reg.div_m1 <= // RULE14
		pocps_pkg::IN_DIV_MAX_M1)
		else $error("input divider beyond 52");
	fb_lost_a: assert property (s_reg.loop == pocps_pkg::LOOP_LOST && // RULE11
		!s_reg.hold |=> s_reg.fw == pocps_pkg::FW_MAX)
		else $error("lost feedback did not raise frequency");
	ref_mux_a: assert property (s_reg.ref_d == $past(ref_mux)) // RULE7
		else $error("reference mux not steered by select");
	irq_level_a: assert property ($rose(s_reg.loop == pocps_pkg::LOOP_LOCK)
		|-> s_reg.irq_stat[pocps_pkg::IRQ_LOCK_BIT])
		else $error("lock event not recorded");
	write_resp_a: assert property (s_reg.bvalid && !S_AXI_BREADY_I |=>
		s_reg.bvalid && $stable(s_reg.bresp))
		else $error("write response dropped early");
endmodule

// ==== pocps_partner.sv ====
// Reference clock sources and feedback return path for the synthesizer
`timescale 1ns/10ps
module pocps_partner #(
	// One tap period of 512 system cycles at reset fw, so D = M = 1 fits
	parameter realtime HALF = 12800.0
) (
	// Controls from the bench and the feedback clock from the block
	input wire logic pri_en_i,
	input wire logic fb_en_i,
	input wire logic fb_out_i,
	// Clocks towards the block
	output logic pri_o,
	output logic alt_o,
	output logic fb_in_o
);
	logic ph = 1'b0;
	// Offset start keeps reference edges away from system clock edges
	initial begin
		#7;
		forever #(HALF) ph = ~ph;
	end
	assign pri_o = ph & pri_en_i;
	assign alt_o = ph;
	// A lost feedback clock is a line stuck low
	assign fb_in_o = fb_out_i & fb_en_i;
endmodule

// ==== pocps_top_tb.sv ====
// Testbench: registers, output counters and interrupts of the synthesizer
`timescale 1ns/10ps
module pocps_top_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic bry = 1'b0;
	logic arv = 1'b0;
	logic rry = 1'b0;
	logic sel = 1'b0;
	logic fb_en = 1'b0;
	logic [3:0] ws = 4'hf;
	logic pri;
	logic alt;
	logic fbi;
	logic fbo;
	logic awr, wr_, bv, arr, rv, lk, irq;
	logic [1:0] br, rr;
	logic [31:0] rdat;
	logic [3:0] oc;
	logic [7:0] ph;
	logic [31:0] d;
	logic [1:0] r;
	logic [31:0] cfg [4] = '{32'h101, 32'h40101, 32'h102, 32'h1000102};
	int cnt [13];
	int t1 [13];
	int err_total = 0;
	int num_checks = 0;
	always #25 clk = ~clk;
	pocps_partner pocps_partner_i (.pri_en_i(1'b0), .fb_en_i(fb_en),
		.fb_out_i(fbo), .pri_o(pri), .alt_o(alt), .fb_in_o(fbi));
	pocps_top pocps_top_i (.CLK_I(clk), .RSTN_I(rstn),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
		.S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_),
		.S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
		.PRIMARY_REF_CLOCK_I(pri), .ALTERNATE_REF_CLOCK_I(alt),
		.REF_INPUT_SELECT_I(sel), .FEEDBACK_CLOCK_IN_I(fbi),
		.FEEDBACK_CLOCK_OUT_O(fbo), .OUTPUT_CLOCK_O(oc),
		.OSC_PHASE_O(ph), .LOCKED_O(lk), .IRQ_O(irq));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("Checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tmo();
		err_total++;
		$display("BAD wait exp done got timeout");
		summarize();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wr_;
			tb = bv;
			r = br;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tb) begin
				bry <= 1'b0;
				return;
			end
		end
		tmo();
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tb;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(negedge clk);
			ta = arv && arr;
			tb = rv;
			d = rdat;
			r = rr;
			@(posedge clk);
			if (ta) arv <= 1'b0;
			if (tb) begin
				rry <= 1'b0;
				return;
			end
		end
		tmo();
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		rd(a);
		chk(nm, e, d);
		chk(nm, {30'h0, pocps_pkg::RESP_OKAY}, {30'h0, r});
	endtask
	// Waits on the lock flag (s = 0) or the interrupt line (s = 1)
	task automatic waitfor(input int s, input int lim);
		for (int n = 0; n < lim; n++) begin
			@(negedge clk);
			if ((s == 0) ? lk : irq) return;
		end
		tmo();
	endtask
	// Counts rising edges of taps (0..7), outputs (8..11), feedback (12)
	task automatic watch(input int n);
		logic [12:0] p, c;
		for (int k = 0; k < 13; k++) begin
			cnt[k] = 0;
			t1[k] = 0;
		end
		@(negedge clk);
		p = {fbo, oc, ph};
		for (int i = 1; i <= n; i++) begin
			@(negedge clk);
			c = {fbo, oc, ph};
			for (int k = 0; k < 13; k++) begin
				if (c[k] && !p[k]) begin
					cnt[k]++;
					if (t1[k] == 0) t1[k] = i;
				end
			end
			p = c;
		end
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rdc("ctrl", pocps_pkg::OFS_CTRL, 32'h1);
		rdc("divs", pocps_pkg::OFS_DIVS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rdc("ocfg", pocps_pkg::OFS_OCFG + 8'(4 * i), 32'h100);
		end
		rd(8'h40);
		chk("unmapped rd", {30'h0, pocps_pkg::RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		wr(8'h44, 32'h1);
		chk("unmapped wr", {30'h0, pocps_pkg::RESP_SLVERR}, {30'h0, r});
		wr(pocps_pkg::OFS_DIVS, 32'h3f3f);
		rdc("divs max", pocps_pkg::OFS_DIVS, 32'h3f33);
		wr(pocps_pkg::OFS_DIVS, 32'h0);
		ws <= 4'h2;
		wr(pocps_pkg::OFS_DIVS, 32'h0505);
		ws <= 4'hf;
		rdc("divs strb", pocps_pkg::OFS_DIVS, 32'h0500);
		wr(pocps_pkg::OFS_DIVS, 32'h0);
		wr(pocps_pkg::OFS_OCFG, 32'h7f);
		rdc("ratio max", pocps_pkg::OFS_OCFG, 32'h7f);
		for (int i = 0; i < 4; i++) begin
			wr(pocps_pkg::OFS_OCFG + 8'(4 * i), cfg[i]);
			rdc("ocfg", pocps_pkg::OFS_OCFG + 8'(4 * i), cfg[i]);
		end
		wr(pocps_pkg::OFS_IRQ_MASK, 32'h4);
		// Primary source is dead, so only the alternate can lock
		@(posedge clk);
		sel <= 1'b1;
		wr(pocps_pkg::OFS_CTRL, 32'h0);
		watch(8192);
		chk("tap start", 32'h1, 32'(t1[0] > 0));
		chk("fb rate", 32'h1, 32'((cnt[12] - cnt[0]) inside {[-1:1]}));
		for (int k = 1; k < 8; k++) begin
			chk("tap order", 32'h1, 32'(t1[k - 1] < t1[k]));
			chk("tap rate", 32'h1, 32'((cnt[k] - cnt[0]) inside {[-1:1]}));
		end
		chk("out0 rate", 32'h1, 32'((cnt[8] * 2 - cnt[0]) inside {[-2:2]}));
		chk("out1 rate", 32'h1, 32'((cnt[9] * 2 - cnt[0]) inside {[-2:2]}));
		chk("out2 rate", 32'h1, 32'((cnt[10] * 3 - cnt[0]) inside {[-3:3]}));
		chk("out1 shift", 32'h1, 32'((t1[9] - t1[8]) inside {[192:320]}));
		chk("out3 delay", 32'h1, 32'((t1[11] - t1[10]) inside {[384:640]}));
		waitfor(0, 30000);
		chk("masked irq", 32'h0, {31'h0, irq});
		wr(pocps_pkg::OFS_IRQ_MASK, 32'h7);
		@(negedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		rd(pocps_pkg::OFS_IRQ_STAT);
		chk("lock event", 32'h1, {31'h0, d[pocps_pkg::IRQ_LOCK_BIT]});
		@(negedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rdc("irq stat", pocps_pkg::OFS_IRQ_STAT, 32'h0);
		wr(pocps_pkg::OFS_IRQ_MASK, 32'h4);
		wr(pocps_pkg::OFS_CTRL, 32'h2);
		waitfor(1, 30000);
		rd(pocps_pkg::OFS_STATUS);
		chk("fw max", 32'hffff, {16'h0, d[31:16]});
		chk("loop lost", 32'h3, {30'h0, d[1:0]});
		watch(2048);
		chk("fast out", 32'h1, 32'(cnt[8] > 64));
		summarize();
	end
endmodule
